// *** dv/sfbp_host.sv ***
// sfbp_host: serial bus host model, single-wire and quad lanes
// assumes the bench calls its tasks; quad_io_out[1] is the device output
`timescale 1ns/100ps
module sfbp_host (
  // link pins
  output logic ce_n,
  output logic sck,
  output logic [3:0] io,
  // device drive
  input wire logic [3:0] quad_io_out,
  input wire logic [3:0] quad_io_oe
);
  logic idle_hi;
  initial begin
    idle_hi = 1'b0;
    ce_n = 1'b1;
    sck = 1'b0;
    io = 4'hF;
  end
  task start(input logic mode3);
    idle_hi = mode3;
    sck = mode3;
    #60 ce_n = 1'b0;
    #60;
  endtask : start
  task xb(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      io[0] = b[i];
      #62.5 sck = 1'b1;
      r[i] = quad_io_oe[1] ? quad_io_out[1] : 1'bx;
      #62.5;
    end
  endtask : xb
  task xq(input logic [7:0] b, output logic [7:0] r);
    for (int i = 1; i >= 0; i--) begin
      sck = 1'b0;
      io = b[4*i+:4];
      #62.5 sck = 1'b1;
      r[4*i+:4] = (quad_io_oe == 4'hF) ? quad_io_out : 4'hx;
      #62.5;
    end
  endtask : xq
  task stop;
    #62.5 sck = idle_hi;
    #30 ce_n = 1'b1;
    io[0] = ~io[0];
    #200;
  endtask : stop
  task set_wp(input logic v);
    io[2] = v;
  endtask : set_wp
  task pause(input int n);
    sck = 1'b0;
    io[3] = 1'b0;
    repeat (n) begin
      #62.5 sck = 1'b1;
      #62.5 sck = 1'b0;
    end
    #62.5;
  endtask : pause
  task resume;
    io[3] = 1'b1;
    #62.5;
  endtask : resume
endmodule : sfbp_host

// *** dv/sfbp_top_tb.sv ***
// sfbp_top_tb: self-checking bench of the protection front end
// assumes sfbp_host drives the link; array data made from the address
`timescale 1ns/100ps
module sfbp_top_tb;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic ce_n, sck;
  logic [3:0] io, quad_io_out, quad_io_oe;
  logic [20:0] mem_addr;
  logic [7:0] mem_rdata, r;
  logic [47:0] block_protect_map;
  logic [39:0] permanent_lock_reg;
  logic lockdown, quad_mode;
  int mismatches = 0;
  int cmp_count = 0;
  localparam logic [47:0] MAP_A = 48'h1234_5678_9AB2;
  localparam logic [47:0] MAP_P = 48'h0000_0001_8AA3;
  localparam logic [39:0] PERM_A = 40'h00_0000_0101;
  always #4 mclk = ~mclk;
  assign mem_rdata = mem_addr[7:0] ^ 8'h5A;
  sfbp_top uut (.mclk(mclk), .rstn(rstn), .ce_n(ce_n), .sck(sck),
    .quad_io_in(io), .quad_io_out(quad_io_out), .quad_io_oe(quad_io_oe),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .block_protect_map(block_protect_map),
    .permanent_lock_reg(permanent_lock_reg), .lockdown(lockdown),
    .quad_mode(quad_mode));
  sfbp_host host (.ce_n(ce_n), .sck(sck), .io(io),
    .quad_io_out(quad_io_out), .quad_io_oe(quad_io_oe));
  task chk(input string n, input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task cmd1(input logic [7:0] op);
    host.start(1'b0);
    host.xb(op, r);
    host.stop;
  endtask : cmd1
  task cmd2(input logic [7:0] op, input logic [7:0] d);
    host.start(1'b0);
    host.xb(op, r);
    host.xb(d, r);
    host.stop;
  endtask : cmd2
  task status(output logic [7:0] s);
    host.start(1'b1);
    host.xb(8'h13, s);
    host.xb(8'h00, s);
    host.stop;
  endtask : status
  task wr_map(input logic [47:0] m);
    host.start(1'b0);
    host.xb(8'h17, r);
    for (int k = 5; k >= 0; k--) host.xb(m[8*k+:8], r);
    host.stop;
  endtask : wr_map
  task wr_perm(input logic [39:0] p);
    host.start(1'b0);
    host.xb(8'h1A, r);
    for (int k = 4; k >= 0; k--) host.xb(p[8*k+:8], r);
    host.stop;
  endtask : wr_perm
  task do_reset;
    @(negedge mclk) rstn <= 1'b0;
    repeat (5) @(negedge mclk);
    rstn <= 1'b1;
    repeat (10) @(negedge mclk);
    chk("map", block_protect_map, 48'hFFFF_FFFF_5555);
    chk("lockdown", {47'h0, lockdown}, 48'h0);
    chk("quad", {47'h0, quad_mode}, 48'h0);
    chk("oe", {44'h0, quad_io_oe}, 48'h0);
    $display("test reset done");
  endtask : do_reset
  task t_map;
    logic [7:0] s;
    wr_map(MAP_A);
    chk("map no enable", block_protect_map, 48'hFFFF_FFFF_5555);
    cmd1(8'h10);
    status(s);
    chk("enable bit", {40'h0, s}, 48'h02);
    wr_map(MAP_A);
    chk("map written", block_protect_map, MAP_A);
    status(s);
    chk("enable cleared", {40'h0, s}, 48'h00);
    $display("test map write done");
  endtask : t_map
  task t_unlock;
    cmd1(8'h10);
    cmd1(8'h18);
    chk("unlock", block_protect_map, MAP_A & 48'h0000_0000_AAAA);
    $display("test unlock done");
  endtask : t_unlock
  task t_read;
    logic [7:0] d;
    host.start(1'b0);
    host.xb(8'h12, d);
    repeat (4) host.xb(8'h00, d);
    host.stop;
    chk("locked read", {40'h0, d}, 48'h00);
    host.start(1'b0);
    host.xb(8'h12, d);
    host.xb(8'h01, d);
    host.xb(8'h00, d);
    host.xb(8'h00, d);
    host.xb(8'h00, d);
    host.stop;
    chk("open read", {40'h0, d}, 48'h5A);
    $display("test read done");
  endtask : t_read
  task t_pin;
    logic [47:0] m;
    m = block_protect_map;
    cmd1(8'h10);
    cmd2(8'h15, 8'h80);
    host.set_wp(1'b0);
    cmd1(8'h10);
    wr_map(48'hFFFF_FFFF_FFFF);
    chk("pin blocks map", block_protect_map, m);
    host.set_wp(1'b1);
    $display("test protect pin done");
  endtask : t_pin
  task t_hold;
    logic [7:0] s;
    cmd1(8'h10);
    host.start(1'b0);
    host.xb(8'h13, s);
    host.pause(2);
    chk("hold oe", {44'h0, quad_io_oe}, 48'h0);
    host.resume;
    host.xb(8'h00, s);
    host.stop;
    chk("hold status", {40'h0, s}, 48'h02);
    $display("test hold done");
  endtask : t_hold
  task t_perm;
    cmd1(8'h10);
    wr_perm(PERM_A);
    chk("perm reg", {8'h0, permanent_lock_reg}, {8'h0, PERM_A});
    chk("perm map", block_protect_map, MAP_P);
    cmd1(8'h10);
    wr_perm(40'h00_0000_0000);
    chk("perm zero", {8'h0, permanent_lock_reg}, {8'h0, PERM_A});
    cmd1(8'h10);
    cmd1(8'h18);
    chk("perm after unlock", block_protect_map, MAP_P);
    $display("test permanent lock done");
  endtask : t_perm
  task t_quad;
    logic [7:0] s;
    logic [47:0] m;
    cmd1(8'h11);
    chk("quad on", {47'h0, quad_mode}, 48'h1);
    host.start(1'b0);
    host.xq(8'h13, s);
    host.xq(8'h00, s);
    host.stop;
    chk("quad status", {40'h0, s}, 48'h12);
    host.start(1'b0);
    host.xq(8'h16, s);
    for (int k = 5; k >= 0; k--) begin
      host.xq(8'h00, s);
      m[8*k+:8] = s;
    end
    host.stop;
    chk("quad map read", m, MAP_P);
    host.start(1'b1);
    host.xq(8'h14, s);
    host.xq(8'h00, s);
    host.stop;
    chk("quad config", {40'h0, s}, 48'h80);
    $display("test quad done");
  endtask : t_quad
  task t_lock;
    logic [7:0] s;
    logic [47:0] m;
    m = block_protect_map;
    cmd1(8'h10);
    cmd1(8'h19);
    status(s);
    chk("lock status", {47'h0, s[4]}, 48'h1);
    cmd1(8'h10);
    wr_map(48'hFFFF_FFFF_FFFF);
    chk("locked map", block_protect_map, m);
    cmd1(8'h18);
    chk("lock stays", {47'h0, lockdown}, 48'h1);
    $display("test lock-down done");
  endtask : t_lock
  initial begin
    #400_000;
    mismatches++;
    wrap_up;
  end
  initial begin
    do_reset;
    t_map;
    t_unlock;
    t_read;
    t_pin;
    t_hold;
    t_perm;
    t_lock;
    t_quad;
    do_reset;
    wrap_up;
  end
endmodule : sfbp_top_tb

// *** hdl/sfbp_lockmap.sv ***
// sfbp_lockmap: protection map, permanent lock bits, lock-down
// assumes callers already checked write enable, and the protect pin for map writes and unlock
`timescale 1ns/100ps
`include "sfbp_params.svh"
module sfbp_lockmap #(
  parameter int AW = 21
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // update requests
  input wire logic wr_map,
  input wire logic [`SFBP_MAP_BITS-1:0] map_data,
  input wire logic unlock_all,
  input wire logic lock_down,
  input wire logic wr_perm,
  input wire logic [`SFBP_PERM_BITS-1:0] perm_data,
  // read check
  input wire logic [AW-1:0] rd_addr,
  output logic rd_locked,
  // state
  output logic [`SFBP_MAP_BITS-1:0] block_protect_map,
  output logic [`SFBP_PERM_BITS-1:0] permanent_lock_reg,
  output logic lockdown
);
  localparam int MB = `SFBP_MAP_BITS;
  localparam int PB = `SFBP_PERM_BITS;
  localparam int NP = `SFBP_PARAM_BLKS;
  logic [MB-1:0] perm_exp;
  logic [MB-1:0] new_exp;
  logic [MB-1:0] wl_mask;

  // write-lock position of each permanent bit
  genvar i;
  for (i = 0; i < PB; i++) begin : g_perm
    localparam int MI = (i < NP) ? 2 * i : i + NP;
    assign perm_exp[MI] = permanent_lock_reg[i];
    assign new_exp[MI] = perm_data[i];
    assign wl_mask[MI] = 1'b1;
  end
  for (i = 0; i < NP; i++) begin : g_rdlk
    assign perm_exp[2 * i + 1] = 1'b0;
    assign new_exp[2 * i + 1] = 1'b0;
    assign wl_mask[2 * i + 1] = 1'b0;
  end

  // parameter block read-lock of an address
  function automatic logic read_locked(input logic [AW-1:0] a,
                                       input logic [MB-1:0] m);
    logic bot;
    logic top;
    logic [2:0] blk;
    bot = (a[AW-1:`SFBP_REGION_SHIFT] == '0);
    top = &a[AW-1:`SFBP_REGION_SHIFT];
    blk = {top, a[`SFBP_REGION_SHIFT-1:`SFBP_PARAM_SHIFT]};
    return (bot || top) && m[{blk, 1'b1}];
  endfunction : read_locked

  assign rd_locked = read_locked(rd_addr, block_protect_map);

  // lock-down, only reset clears it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lockdown <= 1'b0;
    end else if (lock_down) begin
      lockdown <= 1'b1;
    end
  end

  // permanent lock bits, set only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      permanent_lock_reg <= `SFBP_PERM_RESET;
    end else if (wr_perm && !lockdown) begin
      permanent_lock_reg <= permanent_lock_reg | perm_data;
    end
  end

  // protection map
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      block_protect_map <= `SFBP_MAP_RESET;
    end else if (!lockdown) begin
      if (wr_perm) begin
        block_protect_map <= block_protect_map | new_exp;
      end else if (wr_map) begin
        block_protect_map <= map_data | perm_exp;
      end else if (unlock_all) begin
        block_protect_map <= (block_protect_map & ~wl_mask)
                             | perm_exp;
      end
    end
  end

  property p_lock_freeze;
    @(posedge mclk) disable iff (!rst_n)
    lockdown |=> $stable(block_protect_map);
  endproperty
  a_lock_freeze: assert property (p_lock_freeze)
    else $error("map changed under lock-down");

  property p_lock_stays;
    @(posedge mclk) disable iff (!rst_n)
    lockdown |=> lockdown [*3];
  endproperty
  a_lock_stays: assert property (p_lock_stays)
    else $error("lock-down cleared");

  property p_unlock;
    @(posedge mclk) disable iff (!rst_n)
    unlock_all && !lockdown && !wr_perm && !wr_map |=>
      ((block_protect_map & wl_mask) == perm_exp) &&
      ((block_protect_map & ~wl_mask) == ($past(block_protect_map)
                                          & ~wl_mask));
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("global unlock result wrong");

  property p_perm_held;
    @(posedge mclk) disable iff (!rst_n)
    ($past(permanent_lock_reg) & ~permanent_lock_reg) == '0 &&
      (block_protect_map & perm_exp) == perm_exp;
  endproperty
  a_perm_held: assert property (p_perm_held)
    else $error("permanent lock lost");

  property p_perm_zero;
    @(posedge mclk) disable iff (!rst_n)
    wr_perm && perm_data == '0 |=> $stable(permanent_lock_reg)
                                  && $stable(block_protect_map);
  endproperty
  a_perm_zero: assert property (p_perm_zero)
    else $error("zero write changed lock state");

  property p_reset_map;
    @(posedge mclk) $rose(rst_n) |->
      block_protect_map == `SFBP_MAP_RESET && !lockdown;
  endproperty
  a_reset_map: assert property (p_reset_map)
    else $error("map not protected after reset");
endmodule : sfbp_lockmap

// *** hdl/sfbp_params.svh ***
// sfbp_params.svh: constants of the flash protection front end
// assumes inclusion by sfbp_top and sfbp_lockmap, before the package
`ifndef SFBP_PARAMS_SVH
`define SFBP_PARAMS_SVH
// opcodes
`define SFBP_OP_WR_ENABLE 8'h10
`define SFBP_OP_QUAD_ENTER 8'h11
`define SFBP_OP_READ 8'h12
`define SFBP_OP_RD_STATUS 8'h13
`define SFBP_OP_RD_CONFIG 8'h14
`define SFBP_OP_WR_CONFIG 8'h15
`define SFBP_OP_RD_MAP 8'h16
`define SFBP_OP_WR_MAP 8'h17
`define SFBP_OP_UNLOCK_ALL 8'h18
`define SFBP_OP_LOCKDOWN 8'h19
`define SFBP_OP_WR_PERM 8'h1A
// field positions
`define SFBP_SR_WEL 1
`define SFBP_SR_LOCKDOWN 4
`define SFBP_CFG_IO 1
`define SFBP_CFG_PIN_EN 7
`define SFBP_PARAM_SHIFT 13
`define SFBP_REGION_SHIFT 15
// sizes
`define SFBP_MAP_BITS 48
`define SFBP_PERM_BITS 40
`define SFBP_PARAM_BLKS 8
`define SFBP_MAP_BYTES 3'h6
`define SFBP_PERM_BYTES 3'h5
`define SFBP_CFG_BYTES 3'h1
`define SFBP_ADDR_LAST 3'h2
`define SFBP_IDX_MAX 3'h7
`define SFBP_STEP_X1 3'h1
`define SFBP_STEP_X4 3'h4
// reset and fixed values
`define SFBP_MAP_RESET 48'hFFFF_FFFF_5555
`define SFBP_PERM_RESET 40'h00_0000_0000
`define SFBP_CFG_IO_RST 1'b0
`define SFBP_CFG_PIN_RST 1'b0
`define SFBP_PIN_RST 6'h20
`define SFBP_LOCKED_DATA 8'h00
`define SFBP_SO_MASK 4'h2
`endif

// *** hdl/sfbp_pkg.sv ***
// sfbp_pkg: types shared by the flash protection front end
// assumes sfbp_params.svh is compiled alongside
package sfbp_pkg;
  typedef enum logic [2:0] {
    ST_CMD, ST_ADDR, ST_WRITE_IN, ST_DATA_OUT, ST_SKIP
  } sfbp_state_e;
  typedef struct packed {
    logic ce_n;
    logic sck;
    logic [3:0] io;
  } sfbp_pins_s;
  typedef struct packed {
    logic io_cfg;
    logic pin_en;
  } sfbp_cfg_s;
endpackage : sfbp_pkg

// *** hdl/sfbp_sync.sv ***
// sfbp_sync: two-flop synchroniser, one per bit
// assumes an asynchronous active-low reset
`timescale 1ns/100ps
module sfbp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        meta[i] <= RST[i];
        q[i] <= RST[i];
      end else begin
        meta[i] <= d[i];
        q[i] <= meta[i];
      end
    end
  end
endmodule : sfbp_sync

// *** hdl/sfbp_top.sv ***
// sfbp_top: serial flash front end with block protection
// assumes a host driving select and clock, array read port on mclk
`timescale 1ns/100ps
`include "sfbp_params.svh"
module sfbp_top #(
  parameter int AW = 21
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // serial link pins
  input wire logic ce_n,
  input wire logic sck,
  input wire logic [3:0] quad_io_in,
  output logic [3:0] quad_io_out,
  output logic [3:0] quad_io_oe,
  // array read port
  output logic [AW-1:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  // protection state
  output logic [`SFBP_MAP_BITS-1:0] block_protect_map,
  output logic [`SFBP_PERM_BITS-1:0] permanent_lock_reg,
  output logic lockdown,
  output logic quad_mode
);
  logic rst_n;
  sfbp_pkg::sfbp_pins_s pins_raw;
  sfbp_pkg::sfbp_pins_s pins;
  sfbp_pkg::sfbp_state_e state;
  sfbp_pkg::sfbp_cfg_s cfg;
  logic sck_d;
  logic ce_d;
  logic sel;
  logic sck_rise;
  logic sck_fall;
  logic ce_rise;
  logic live_rise;
  logic live_fall;
  logic hold_q;
  logic [2:0] bit_cnt;
  logic [2:0] step;
  logic [7:0] rx_sh;
  logic [7:0] rx_byte;
  logic byte_done;
  logic [7:0] cmd;
  logic [2:0] byte_idx;
  logic [`SFBP_MAP_BITS-1:0] in_buf;
  logic [AW-1:0] addr;
  logic [7:0] tx_sh;
  logic [7:0] tx_next;
  logic tx_live;
  logic wel;
  logic wp_block;
  logic fin;
  logic go_wel;
  logic go_quad;
  logic go_cfg;
  logic go_wr_map;
  logic go_unlock;
  logic go_lock;
  logic go_perm;
  logic rd_locked;

  // reset release
  sfbp_sync #(.W(1), .RST(1'b0)) u_rst (
    .mclk(mclk),
    .rst_n(rstn),
    .d(1'b1),
    .q(rst_n)
  );

  // pin synchronisers
  assign pins_raw = {ce_n, sck, quad_io_in};
  sfbp_sync #(
    .W($bits(sfbp_pkg::sfbp_pins_s)),
    .RST(`SFBP_PIN_RST)
  ) u_pins (
    .mclk(mclk),
    .rst_n(rst_n),
    .d(pins_raw),
    .q(pins)
  );

  // edge finding on the link clock and select
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sck_d <= 1'b0;
      ce_d <= 1'b1;
    end else begin
      sck_d <= pins.sck;
      ce_d <= pins.ce_n;
    end
  end

  assign sel = !pins.ce_n;
  assign sck_rise = sel && pins.sck && !sck_d;
  assign sck_fall = sel && !pins.sck && sck_d;
  assign ce_rise = !ce_d && pins.ce_n;
  assign live_rise = sck_rise && !hold_q;
  assign live_fall = sck_fall && !hold_q;

  // hold, taken only while the clock is low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= 1'b0;
    end else if (!sel || quad_mode) begin
      hold_q <= 1'b0;
    end else if (!pins.sck) begin
      hold_q <= !pins.io[3];
    end
  end

  // input shifting
  assign step = quad_mode ? `SFBP_STEP_X4 : `SFBP_STEP_X1;

  always_comb begin
    if (quad_mode) begin
      rx_byte = {rx_sh[3:0], pins.io};
    end else begin
      rx_byte = {rx_sh[6:0], pins.io[0]};
    end
  end

  assign byte_done = live_rise && (3'(bit_cnt + step) == 3'h0);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= 3'h0;
      rx_sh <= 8'h00;
    end else if (!sel) begin
      bit_cnt <= 3'h0;
      rx_sh <= 8'h00;
    end else if (live_rise) begin
      bit_cnt <= bit_cnt + step;
      rx_sh <= rx_byte;
    end
  end

  // next phase after an opcode
  function automatic sfbp_pkg::sfbp_state_e phase_of(
      input logic [7:0] op);
    case (op)
      `SFBP_OP_READ: return sfbp_pkg::ST_ADDR;
      `SFBP_OP_RD_STATUS,
      `SFBP_OP_RD_CONFIG,
      `SFBP_OP_RD_MAP: return sfbp_pkg::ST_DATA_OUT;
      `SFBP_OP_WR_CONFIG,
      `SFBP_OP_WR_MAP,
      `SFBP_OP_WR_PERM: return sfbp_pkg::ST_WRITE_IN;
      default: return sfbp_pkg::ST_SKIP;
    endcase
  endfunction : phase_of

  // command sequencing
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= sfbp_pkg::ST_CMD;
      cmd <= 8'h00;
      byte_idx <= 3'h0;
    end else if (!sel) begin
      state <= sfbp_pkg::ST_CMD;
      byte_idx <= 3'h0;
    end else if (byte_done) begin
      case (state)
        sfbp_pkg::ST_CMD: begin
          cmd <= rx_byte;
          state <= phase_of(rx_byte);
          byte_idx <= 3'h0;
        end
        sfbp_pkg::ST_ADDR: begin
          if (byte_idx == `SFBP_ADDR_LAST) begin
            state <= sfbp_pkg::ST_DATA_OUT;
            byte_idx <= 3'h0;
          end else begin
            byte_idx <= byte_idx + 3'h1;
          end
        end
        sfbp_pkg::ST_WRITE_IN,
        sfbp_pkg::ST_DATA_OUT: begin
          if (byte_idx != `SFBP_IDX_MAX) begin
            byte_idx <= byte_idx + 3'h1;
          end
        end
        default: begin
          state <= sfbp_pkg::ST_SKIP;
        end
      endcase
    end
  end

  // address and write data capture
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      addr <= '0;
      in_buf <= '0;
    end else if (byte_done) begin
      if (state == sfbp_pkg::ST_ADDR) begin
        addr <= AW'({addr, rx_byte});
      end else if (state == sfbp_pkg::ST_DATA_OUT) begin
        addr <= addr + AW'(1);
      end
      if (state == sfbp_pkg::ST_WRITE_IN) begin
        in_buf <= {in_buf[`SFBP_MAP_BITS-9:0], rx_byte};
      end
    end
  end

  assign mem_addr = addr;

  // outgoing byte
  always_comb begin
    tx_next = 8'h00;
    case (cmd)
      `SFBP_OP_RD_STATUS: begin
        tx_next[`SFBP_SR_WEL] = wel;
        tx_next[`SFBP_SR_LOCKDOWN] = lockdown;
      end
      `SFBP_OP_RD_CONFIG: begin
        tx_next[`SFBP_CFG_IO] = cfg.io_cfg;
        tx_next[`SFBP_CFG_PIN_EN] = cfg.pin_en;
      end
      `SFBP_OP_RD_MAP: begin
        if (byte_idx < `SFBP_MAP_BYTES) begin
          tx_next = block_protect_map[
            (int'(`SFBP_MAP_BYTES) - 1 - int'(byte_idx)) * 8 +: 8];
        end
      end
      `SFBP_OP_READ: begin
        tx_next = rd_locked ? `SFBP_LOCKED_DATA : mem_rdata;
      end
      default: begin
        tx_next = 8'h00;
      end
    endcase
  end

  // output shifting on the falling edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh <= 8'h00;
      tx_live <= 1'b0;
    end else if (!sel) begin
      tx_sh <= 8'h00;
      tx_live <= 1'b0;
    end else if (live_fall) begin
      if (bit_cnt == 3'h0) begin
        tx_sh <= tx_next;
        tx_live <= (state == sfbp_pkg::ST_DATA_OUT);
      end else if (quad_mode) begin
        tx_sh <= {tx_sh[3:0], 4'h0};
      end else begin
        tx_sh <= {tx_sh[6:0], 1'b0};
      end
    end
  end

  // pin drive
  always_comb begin
    if (quad_mode) begin
      quad_io_out = tx_sh[7:4];
      quad_io_oe = {4{tx_live && sel}};
    end else begin
      quad_io_out = {2'b00, tx_sh[7], 1'b0};
      quad_io_oe = (tx_live && sel && !hold_q) ? `SFBP_SO_MASK : 4'h0;
    end
  end

  // command execution at deselect
  assign wp_block = !cfg.io_cfg && cfg.pin_en && !pins.io[2]
                    && !quad_mode;
  assign fin = ce_rise && (bit_cnt == 3'h0);
  assign go_wel = fin && state == sfbp_pkg::ST_SKIP
                  && cmd == `SFBP_OP_WR_ENABLE;
  assign go_quad = fin && state == sfbp_pkg::ST_SKIP
                   && cmd == `SFBP_OP_QUAD_ENTER;
  assign go_unlock = fin && state == sfbp_pkg::ST_SKIP
                     && cmd == `SFBP_OP_UNLOCK_ALL && wel && !wp_block
                     && !lockdown;
  assign go_lock = fin && state == sfbp_pkg::ST_SKIP
                   && cmd == `SFBP_OP_LOCKDOWN && wel;
  assign go_wr_map = fin && state == sfbp_pkg::ST_WRITE_IN
                     && cmd == `SFBP_OP_WR_MAP
                     && byte_idx == `SFBP_MAP_BYTES
                     && wel && !wp_block && !lockdown;
  assign go_perm = fin && state == sfbp_pkg::ST_WRITE_IN
                   && cmd == `SFBP_OP_WR_PERM
                   && byte_idx == `SFBP_PERM_BYTES
                   && wel && !lockdown;
  assign go_cfg = fin && state == sfbp_pkg::ST_WRITE_IN
                  && cmd == `SFBP_OP_WR_CONFIG
                  && byte_idx == `SFBP_CFG_BYTES
                  && wel && !wp_block;

  // write enable latch
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wel <= 1'b0;
    end else if (go_wel) begin
      wel <= 1'b1;
    end else if (go_wr_map || go_unlock || go_lock || go_perm
                 || go_cfg) begin
      wel <= 1'b0;
    end
  end

  // bus mode, single-wire from reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      quad_mode <= 1'b0;
    end else if (go_quad) begin
      quad_mode <= 1'b1;
    end
  end

  // configuration bits
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg.io_cfg <= `SFBP_CFG_IO_RST;
      cfg.pin_en <= `SFBP_CFG_PIN_RST;
    end else if (go_cfg) begin
      cfg.io_cfg <= in_buf[`SFBP_CFG_IO];
      cfg.pin_en <= in_buf[`SFBP_CFG_PIN_EN];
    end
  end

  sfbp_lockmap #(.AW(AW)) u_map (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_map(go_wr_map),
    .map_data(in_buf),
    .unlock_all(go_unlock),
    .lock_down(go_lock),
    .wr_perm(go_perm),
    .perm_data(in_buf[`SFBP_PERM_BITS-1:0]),
    .rd_addr(addr),
    .rd_locked(rd_locked),
    .block_protect_map(block_protect_map),
    .permanent_lock_reg(permanent_lock_reg),
    .lockdown(lockdown)
  );

  property p_rx_on_rise;
    @(posedge mclk) disable iff (!rst_n)
    sel && !sck_rise |=> $stable(rx_sh) && $stable(bit_cnt);
  endproperty
  a_rx_on_rise: assert property (p_rx_on_rise)
    else $error("input shifted off the rising edge");

  property p_single_start;
    @(posedge mclk) $rose(rst_n) |-> !quad_mode ##1 !quad_mode;
  endproperty
  a_single_start: assert property (p_single_start)
    else $error("not single-wire after reset");

  property p_quad_enter;
    @(posedge mclk) disable iff (!rst_n)
    go_quad |=> quad_mode ##1 quad_mode;
  endproperty
  a_quad_enter: assert property (p_quad_enter)
    else $error("quad command not taken");

  property p_single_pins;
    @(posedge mclk) disable iff (!rst_n)
    !quad_mode |-> (quad_io_oe & ~`SFBP_SO_MASK) == 4'h0;
  endproperty
  a_single_pins: assert property (p_single_pins)
    else $error("single-wire drives a lane other than output");

  property p_pin_blocks;
    @(posedge mclk) disable iff (!rst_n)
    ce_rise && cmd == `SFBP_OP_WR_MAP && wp_block |=>
      $stable(block_protect_map);
  endproperty
  a_pin_blocks: assert property (p_pin_blocks)
    else $error("map written while protect pin active");

  property p_hold;
    @(posedge mclk) disable iff (!rst_n)
    hold_q && sck_rise |=> $stable(bit_cnt) && quad_io_oe == 4'h0;
  endproperty
  a_hold: assert property (p_hold)
    else $error("transfer advanced during hold");

  property p_read_zero;
    @(posedge mclk) disable iff (!rst_n)
    live_fall && bit_cnt == 3'h0 && cmd == `SFBP_OP_READ
      && state == sfbp_pkg::ST_DATA_OUT && rd_locked
      |=> tx_sh == `SFBP_LOCKED_DATA;
  endproperty
  a_read_zero: assert property (p_read_zero)
    else $error("read-locked block returned data");

  property p_need_enable;
    @(posedge mclk) disable iff (!rst_n)
    $changed(block_protect_map) |-> $past(wel);
  endproperty
  a_need_enable: assert property (p_need_enable)
    else $error("map changed without write enable");

  property p_status_lock;
    @(posedge mclk) disable iff (!rst_n)
    live_fall && bit_cnt == 3'h0 && cmd == `SFBP_OP_RD_STATUS
      && state == sfbp_pkg::ST_DATA_OUT
      |=> tx_sh[`SFBP_SR_LOCKDOWN] == lockdown;
  endproperty
  a_status_lock: assert property (p_status_lock)
    else $error("status does not show lock-down");

  property p_enable_drop;
    @(posedge mclk) disable iff (!rst_n)
    go_wr_map || go_lock |=> !wel;
  endproperty
  a_enable_drop: assert property (p_enable_drop)
    else $error("write enable kept after map change");
endmodule : sfbp_top
